// ==== gpc_defs.svh ====
// Purpose: Constants for the game port capture block
// Assumes: 50 MHz clk, APB with byte addresses
// Notes: Types live in gpc_pkg
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define GPC_ADDR_CTRL 8'h00
`define GPC_ADDR_LEGACY 8'h04
`define GPC_ADDR_TYPE 8'h08
`define GPC_ADDR_SWITCH 8'h0C
`define GPC_ADDR_RES0 8'h20
`define GPC_ADDR_RES7 8'h3C
`define GPC_CTRL_RST 2'h1
`define GPC_CTRL_EN 0
`define GPC_CTRL_HP 1
// ----------------------------------------
// Capture and timing
// ----------------------------------------
`define GPC_NCH 8
`define GPC_CNT_W 13
`define GPC_CNT_MAX 13'h1FFF
`define GPC_RES_HI_W 3
`define GPC_TICK_DIV 2'h3
`define GPC_CLK_NS 20
`define GPC_DISCH_NS 100000
`define GPC_FRAME_NS 11111111
`define GPC_PIN_RST 8'hFF
`endif

// ==== gpc_pkg.sv ====
// Purpose: Types for the game port capture block
// Assumes: Gray-coded capture sequence
// Notes: Constants sit in gpc_defs.svh
package gpc_pkg;
    typedef enum logic [1:0] {
        GPC_IDLE = 2'h0,
        GPC_DISCH = 2'h1,
        GPC_CHARGE = 2'h3,
        GPC_STORE = 2'h2
    } gpc_state_type;
endpackage

// ==== gpc_capture.sv ====
// Purpose: Eight-channel analog/digital game port capture with APB registers
// Assumes: clk is the crystal reference; capture ticks divide it by four
// Notes: One capacitor is shared, so channels are measured in turn
// Contract
// - Eight channels, each measurable as analog position or digital switch.
// - Analog channel charges shared capacitor through its pot; charge time is position.
// - Digital channel reads released while pin floats, pressed while grounded.
// - Unplugged or released channel is classified digital.
// - Game port offers a legacy view and a high-precision view.
// - Legacy view emulates the classic game port byte at host port 0x201.
// - High-precision view refreshes all channels autonomously without processor polling.
// - Analog or digital classification per channel is automatic and readable.
// - Capture timing counts crystal reference periods, never a synthesized clock.
// - Results are 16 bits; capture writes only the low 13.
// - Each channel is measured once per frame, 90 Hz per channel.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "gpc_defs.svh"
module gpc_capture #(
    parameter int unsigned DISCHARGE_CYC = (`GPC_DISCH_NS + `GPC_CLK_NS - 1) / `GPC_CLK_NS,
    parameter int unsigned FRAME_CYC = `GPC_FRAME_NS / `GPC_CLK_NS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] controller_channel_pins,
    input wire logic cap_comparator,
    output logic [7:0] charge_select,
    output logic timing_capacitor_low,
    output gpc_pkg::gpc_state_type capture_phase
);
    import gpc_pkg::*;

    localparam int unsigned SLOT_CYC = FRAME_CYC / `GPC_NCH;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_result(input logic [7:0] a);
        is_result = (a >= `GPC_ADDR_RES0) && (a <= `GPC_ADDR_RES7) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] res_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `GPC_ADDR_RES0;
        res_index = d[4:2];
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `GPC_ADDR_CTRL) || (a == `GPC_ADDR_LEGACY) ||
                  (a == `GPC_ADDR_TYPE) || (a == `GPC_ADDR_SWITCH) || is_result(a);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
    logic [7:0] pin_s1_next, pin_s2_next, pin_s3_next, pin_next;
    logic cmp_s1_reg, cmp_s2_reg, cmp_s3_reg, cmp_reg;
    logic cmp_s1_next, cmp_s2_next, cmp_s3_next, cmp_next;
    logic [1:0] div_reg, div_next;
    logic [31:0] slot_reg, slot_next;
    logic [31:0] wait_reg, wait_next;
    gpc_state_type state_reg, state_next;
    logic [2:0] ch_reg, ch_next;
    logic [`GPC_CNT_W-1:0] cnt_reg, cnt_next;
    logic trip_reg, trip_next;
    logic [7:0] analog_reg, analog_next;
    logic [`GPC_CNT_W-1:0] res_lo_reg [`GPC_NCH];
    logic [`GPC_CNT_W-1:0] res_lo_next [`GPC_NCH];
    logic [`GPC_RES_HI_W-1:0] res_hi_reg [`GPC_NCH];
    logic [`GPC_RES_HI_W-1:0] res_hi_next [`GPC_NCH];
    logic [`GPC_CNT_W-1:0] leg_reg [4];
    logic [`GPC_CNT_W-1:0] leg_next [4];
    logic [1:0] ctrl_reg, ctrl_next;
    logic [7:0] sel_reg, sel_next;
    logic dis_reg, dis_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic tick, setup, wr_acc;
    logic [31:0] rd_data;
    logic [3:0] leg_busy;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign charge_select = sel_reg;
    assign timing_capacitor_low = dis_reg;
    assign capture_phase = state_reg;

    // Crystal-period tick, one cycle in four
    assign tick = (div_reg == 2'h0);
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready_reg && pwrite;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            leg_busy[i] = (leg_reg[i] != '0);
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_data = 32'h0;
        if (paddr == `GPC_ADDR_CTRL) begin
            rd_data[1:0] = ctrl_reg;
        end else if (paddr == `GPC_ADDR_LEGACY) begin
            // Upper nibble: button levels, 1 released
            rd_data[7:0] = {pin_reg[7:4], leg_busy};
        end else if (paddr == `GPC_ADDR_TYPE) begin
            rd_data[7:0] = analog_reg;
        end else if (paddr == `GPC_ADDR_SWITCH) begin
            rd_data[7:0] = ~pin_reg;
        end else if (is_result(paddr)) begin
            rd_data[15:0] = {res_hi_reg[res_index(paddr)], res_lo_reg[res_index(paddr)]};
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        // Pins pass three flops; change taken when last two agree
        pin_s1_next = controller_channel_pins;
        pin_s2_next = pin_s1_reg;
        pin_s3_next = pin_s2_reg;
        pin_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_reg;
        cmp_s1_next = cap_comparator;
        cmp_s2_next = cmp_s1_reg;
        cmp_s3_next = cmp_s2_reg;
        cmp_next = (cmp_s2_reg == cmp_s3_reg) ? cmp_s3_reg : cmp_reg;
        div_next = (div_reg == `GPC_TICK_DIV) ? 2'h0 : div_reg + 2'h1;
        // Fixed slots: each channel once per frame
        slot_next = (slot_reg == 32'(SLOT_CYC - 1)) ? 32'h0 : slot_reg + 32'h1;
        wait_next = wait_reg;
        state_next = state_reg;
        ch_next = ch_reg;
        cnt_next = cnt_reg;
        trip_next = trip_reg;
        analog_next = analog_reg;
        res_lo_next = res_lo_reg;
        res_hi_next = res_hi_reg;
        ctrl_next = ctrl_reg;
        sel_next = sel_reg;
        dis_next = dis_reg;
        for (int i = 0; i < 4; i++) begin
            leg_next[i] = (tick && leg_busy[i]) ? leg_reg[i] - 1'b1 : leg_reg[i];
        end

        // Autonomous sequence, no processor involvement
        case (state_reg)
            GPC_IDLE: begin
                if (slot_reg == 32'h0 && ctrl_reg[`GPC_CTRL_EN]) begin
                    state_next = GPC_DISCH;
                    dis_next = 1'b1;
                    wait_next = 32'h0;
                end
            end
            GPC_DISCH: begin
                wait_next = wait_reg + 32'h1;
                if (wait_reg == 32'(DISCHARGE_CYC - 1)) begin
                    state_next = GPC_CHARGE;
                    dis_next = 1'b0;
                    sel_next = 8'h01 << ch_reg;
                    cnt_next = '0;
                    trip_next = 1'b0;
                end
            end
            GPC_CHARGE: begin
                if (cmp_reg) begin
                    state_next = GPC_STORE;
                    trip_next = 1'b1;
                end else if (tick) begin
                    if (cnt_reg == `GPC_CNT_MAX) begin
                        state_next = GPC_STORE;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            GPC_STORE: begin
                sel_next = 8'h00;
                res_lo_next[ch_reg] = cnt_reg;
                // No trip: no pot, so floating or switch means digital
                analog_next[ch_reg] = trip_reg;
                ch_next = ch_reg + 3'h1;
                state_next = GPC_IDLE;
            end
            default: begin
                state_next = GPC_IDLE;
                sel_next = 8'h00;
                dis_next = 1'b0;
            end
        endcase

        // APB: answer registered in setup, ready in first access cycle
        pready_next = setup;
        pslverr_next = setup && !reg_hit(paddr);
        prdata_next = (setup && !pwrite) ? rd_data : 32'h0;
        if (wr_acc) begin
            if (paddr == `GPC_ADDR_CTRL) begin
                ctrl_next = pwdata[1:0];
            end else if (paddr == `GPC_ADDR_LEGACY) begin
                // Write fires the one-shots with the latest positions
                for (int i = 0; i < 4; i++) begin
                    leg_next[i] = res_lo_reg[i];
                end
            end else if (is_result(paddr)) begin
                res_hi_next[res_index(paddr)] = pwdata[15:13];
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_s1_reg <= `GPC_PIN_RST;
            pin_s2_reg <= `GPC_PIN_RST;
            pin_s3_reg <= `GPC_PIN_RST;
            pin_reg <= `GPC_PIN_RST;
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
            cmp_s3_reg <= 1'b0;
            cmp_reg <= 1'b0;
            div_reg <= 2'h0;
            slot_reg <= 32'h0;
            wait_reg <= 32'h0;
            state_reg <= GPC_IDLE;
            ch_reg <= 3'h0;
            cnt_reg <= '0;
            trip_reg <= 1'b0;
            analog_reg <= 8'h00;
            ctrl_reg <= `GPC_CTRL_RST;
            sel_reg <= 8'h00;
            dis_reg <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            for (int i = 0; i < `GPC_NCH; i++) begin
                res_lo_reg[i] <= '0;
                res_hi_reg[i] <= '0;
            end
            for (int i = 0; i < 4; i++) begin
                leg_reg[i] <= '0;
            end
        end else begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            pin_s3_reg <= pin_s3_next;
            pin_reg <= pin_next;
            cmp_s1_reg <= cmp_s1_next;
            cmp_s2_reg <= cmp_s2_next;
            cmp_s3_reg <= cmp_s3_next;
            cmp_reg <= cmp_next;
            div_reg <= div_next;
            slot_reg <= slot_next;
            wait_reg <= wait_next;
            state_reg <= state_next;
            ch_reg <= ch_next;
            cnt_reg <= cnt_next;
            trip_reg <= trip_next;
            analog_reg <= analog_next;
            ctrl_reg <= ctrl_next;
            sel_reg <= sel_next;
            dis_reg <= dis_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            res_lo_reg <= res_lo_next;
            res_hi_reg <= res_hi_next;
            leg_reg <= leg_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_apb_ready_pulse: assert property (setup |=> pready ##1 !pready)
        else $error("ready did not pulse once after setup");
    a_unmapped_error: assert property (setup && !reg_hit(paddr) |=> pslverr && pready)
        else $error("unmapped access without error");
    a_switch_view: assert property (setup && !pwrite && paddr == `GPC_ADDR_SWITCH
        |=> prdata[7:0] == ~$past(pin_reg))
        else $error("switch view mismatch");
    a_legacy_buttons: assert property (setup && !pwrite && paddr == `GPC_ADDR_LEGACY
        |=> prdata[7:4] == $past(pin_reg[7:4]))
        else $error("legacy button bits wrong");
    a_charge_onehot: assert property (state_reg == GPC_CHARGE |-> $onehot(sel_reg) && !dis_reg)
        else $error("charge select not one-hot");
    a_discharge_held: assert property (state_reg == GPC_DISCH |-> dis_reg && sel_reg == 8'h00)
        else $error("discharge not driven");
    a_tick_only: assert property (state_reg == GPC_CHARGE && !tick |=> $stable(cnt_reg))
        else $error("count moved off tick");
    a_saturate_digital: assert property (state_reg == GPC_STORE && !trip_reg
        |-> cnt_reg == `GPC_CNT_MAX ##1 !analog_reg[$past(ch_reg)])
        else $error("timeout not saturated or not digital");
    a_store_result: assert property (state_reg == GPC_STORE
        |=> res_lo_reg[$past(ch_reg)] == $past(cnt_reg) && analog_reg[$past(ch_reg)] == $past(trip_reg))
        else $error("result or class not stored");
    a_upper_kept: assert property (state_reg == GPC_STORE && !wr_acc
        |=> res_hi_reg[$past(ch_reg)] == $past(res_hi_reg[ch_reg]))
        else $error("capture touched upper bits");
    a_next_channel: assert property (state_reg == GPC_STORE |=> ch_reg == $past(ch_reg) + 3'h1)
        else $error("channel did not advance");
    a_slot_start: assert property ($rose(dis_reg) |-> $past(slot_reg) == 32'h0)
        else $error("capture began off slot");
    a_autonomous: assert property (state_reg == GPC_IDLE && slot_reg == 32'h0 && ctrl_reg[`GPC_CTRL_EN]
        |=> state_reg == GPC_DISCH)
        else $error("slot start missed");
endmodule

// ==== gpc_partner.sv ====
// Purpose: Far-side model of pots and switches on the channel pins
// Assumes: pot_ticks gives per channel the charge time in capture ticks, 0 = no pot
// Notes: Comparator trips only while a pot is selected and discharge is off
`timescale 1ns/10ps
module gpc_partner (
    input wire logic clk,
    input wire logic [7:0] charge_select,
    input wire logic timing_capacitor_low,
    input wire logic [63:0] pot_ticks,
    input wire logic [7:0] pressed,
    output logic [7:0] controller_channel_pins,
    output logic cap_comparator
);
    logic [15:0] charge_cyc;
    logic [7:0] ticks;
    // ----------------------------------------
    // Capacitor charge through the selected pot
    // ----------------------------------------
    always_ff @(posedge clk) begin
        charge_cyc <= (charge_select == 8'h00 || timing_capacitor_low) ? 16'h0000 : charge_cyc + 16'h0001;
    end
    always_comb begin
        ticks = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (charge_select[i]) begin
                ticks = pot_ticks[8*i +: 8];
            end
        end
        // No pot means the cap never reaches threshold
        cap_comparator = (ticks != 8'h00) && ((16'(ticks) << 2) <= charge_cyc);
        for (int i = 0; i < 8; i++) begin
            controller_channel_pins[i] = pressed[i] ? 1'b0 : 1'b1;
        end
    end
endmodule

// ==== game_port_capture_bench.sv ====
// Purpose: Self-checking bench for the game port capture block
// Assumes: Shortened discharge and frame counts; channel 7 has no pot
// Notes: Channel 7 saturation takes about 33k cycles, so the refresh wait is long
`timescale 1ns/10ps
`include "gpc_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module game_port_capture_bench;
    import gpc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [63:0] pot = 64'h0;
    logic [7:0] press = 8'h00;
    logic [15:0] lfsr_state = 16'h9D89;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [7:0] pins;
    wire [7:0] sel;
    wire cmp;
    wire cap_low;
    gpc_state_type phase;
    int fails = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic err;
    logic [15:0] v;
    logic [15:0] keep;
    always #10 clk = ~clk;
    gpc_capture #(.DISCHARGE_CYC(20), .FRAME_CYC(2000)) DUT (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .controller_channel_pins(pins), .cap_comparator(cmp), .charge_select(sel),
        .timing_capacitor_low(cap_low), .capture_phase(phase));
    gpc_partner PARTNER (.clk(clk), .charge_select(sel), .timing_capacitor_low(cap_low), .pot_ticks(pot),
        .pressed(press), .controller_channel_pins(pins), .cap_comparator(cmp));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] rnd();
        lfsr_state = lfsr_state[0] ? ((lfsr_state >> 1) ^ 16'hB400) : (lfsr_state >> 1);
        return lfsr_state;
    endfunction
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(pready, 1'b1)
    endtask
    task new_pots();
        for (int n = 0; n < 7; n++) begin
            v = rnd();
            pot[8*n +: 8] <= {2'b00, v[5:0]} + 8'h08;
        end
        pot[63:56] <= 8'h00;
    endtask
    task check_results();
        logic [7:0] d;
        for (int n = 0; n < 7; n++) begin
            d = pot[8*n +: 8];
            apb(1'b0, `GPC_ADDR_RES0 + 8'(4*n), 32'h0, rd, err);
            `CHK((rd[12:0] >= 13'(d)) && (rd[12:0] <= 13'(d) + 13'h2), 1'b1)
        end
    endtask
    task complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        new_pots();
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `GPC_ADDR_CTRL, 32'h0, rd, err);
        `CHK(rd[1:0], `GPC_CTRL_RST)
        repeat (3000) @(posedge clk);
        check_results();
        apb(1'b0, `GPC_ADDR_TYPE, 32'h0, rd, err);
        `CHK(rd[7:0], 8'h7F)
        press <= 8'h80;
        repeat (10) @(posedge clk);
        apb(1'b0, `GPC_ADDR_SWITCH, 32'h0, rd, err);
        `CHK(rd[7:0], 8'h80)
        apb(1'b0, `GPC_ADDR_LEGACY, 32'h0, rd, err);
        `CHK(rd[7:4], 4'h7)
        press <= 8'h00;
        apb(1'b1, `GPC_ADDR_LEGACY, 32'h0, rd, err);
        apb(1'b0, `GPC_ADDR_LEGACY, 32'h0, rd, err);
        `CHK(rd[3:0], 4'hF)
        repeat (4 * 75 + 20) @(posedge clk);
        apb(1'b0, `GPC_ADDR_LEGACY, 32'h0, rd, err);
        `CHK(rd[3:0], 4'h0)
        keep = rnd();
        apb(1'b1, `GPC_ADDR_RES0 + 8'h0C, {16'h0000, keep}, rd, err);
        apb(1'b0, `GPC_ADDR_RES0 + 8'h0C, 32'h0, rd, err);
        `CHK(rd[15:13], keep[15:13])
        apb(1'b1, 8'h10, 32'hFFFFFFFF, rd, err);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h10, 32'h0, rd, err);
        `CHK({err, rd}, {1'b1, 32'h0})
        new_pots();
        repeat (42000) @(posedge clk);
        check_results();
        apb(1'b0, `GPC_ADDR_RES7, 32'h0, rd, err);
        `CHK(rd[12:0], `GPC_CNT_MAX)
        // Channel 7 is in its second long saturating charge by now
        `CHK(phase, GPC_CHARGE)
        `CHK({sel, cap_low}, {8'h80, 1'b0})
        apb(1'b0, `GPC_ADDR_TYPE, 32'h0, rd, err);
        `CHK(rd[7:0], 8'h7F)
        apb(1'b0, `GPC_ADDR_RES0 + 8'h0C, 32'h0, rd, err);
        `CHK(rd[15:13], keep[15:13])
        complete_run();
    end
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
